// File: verilog/adtr_pkg.sv
// adtr_pkg: constants for the analog die trim register bank.
// assumes one 40 MHz core clock and an active-low asynchronous reset.
package adtr_pkg;

    // ****************************************
    // address windows and offsets
    // ****************************************
    localparam int ADTR_ADDR_W = 10; // global window address width
    localparam logic [9:0] ADTR_BASE_BLOCKING = 10'h200; // blocking access window
    localparam logic [9:0] ADTR_BASE_NONBLOCK = 10'h300; // non-blocking access window
    localparam logic [7:0] ADTR_OFS_ZERO = 8'hf0; // watchdog oscillator trim
    localparam logic [7:0] ADTR_OFS_ONE = 8'hf1; // bandgap and reference current trim
    localparam logic [7:0] ADTR_OFS_TWO = 8'hf2; // sleep bandgap trim, lockable
    localparam logic [7:0] ADTR_OFS_THREE = 8'hf3; // offset trim
    localparam int ADTR_NREGS = 4; // number of trim registers
    localparam logic [9:0] ADTR_WIN_MASK = 10'h0ff; // offset bits inside a window
    localparam logic [9:0] ADTR_BASE_MASK = 10'h300; // base bits of a window

    // ****************************************
    // reset values (not fixed by the silicon notes)
    // ****************************************
    localparam logic [7:0] ADTR_RST_ZERO = 8'h00;
    localparam logic [7:0] ADTR_RST_ONE = 8'h00;
    localparam logic [7:0] ADTR_RST_TWO = 8'h00;
    localparam logic [7:0] ADTR_RST_THREE = 8'h00;

    // ****************************************
    // sleep bandgap trim field layout
    // ****************************************
    localparam int ADTR_SLP_EN_BIT = 4; // sleep_ref_trim_enable
    localparam int ADTR_SLP_LOCK_BIT = 3; // sleep_ref_trim_lock
    localparam int ADTR_SLP_STEP_HI = 2; // sleep_ref_trim_step msb
    localparam logic [7:0] ADTR_SLP_MASK = 8'h1f; // implemented bits, rest read zero

endpackage : adtr_pkg

// File: verilog/adtr_trim_bank.sv
// adtr_trim_bank: four 8-bit analog trim registers behind the die-to-die register port.
// assumes the port is synchronous to core_clk and that software loads the factory
// bytes at start-up; low-power mode only holds state, nothing is cleared by it.
`timescale 1ns/100ps

// Contract
// - values hold in low power, reset restores defaults
// - four 8-bit trim registers, third lockable
// - decode offsets at bases 0x200 and 0x300
// - locked sleep trim refuses any change
module adtr_trim_bank
    import adtr_pkg::*;
(
    input wire logic core_clk, // 40 MHz system clock
    input wire logic nrst, // asynchronous reset, active low
    input wire logic low_power, // low-power mode indication
    input wire logic [adtr_pkg::ADTR_ADDR_W-1:0] reg_addr, // global window address
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic reg_wide, // 16-bit access at any offset but the last
    input wire logic [15:0] reg_wdata, // high byte to lower offset
    output logic [15:0] reg_rdata, // registered read data
    output logic reg_ack, // one-cycle answer to a mapped access
    output logic [7:0] trim_reg_zero, // watchdog oscillator trim
    output logic [7:0] trim_reg_one, // bandgap and reference current trim
    output logic [7:0] trim_reg_two, // sleep bandgap trim
    output logic [7:0] trim_reg_three, // offset trim
    output logic sleep_ref_trim_locked // sleep bandgap trim is frozen
);
    import adtr_pkg::*;

    // ****************************************
    // address decode
    // ****************************************
    logic win_hit; // address lies in either window
    logic [7:0] ofs; // offset inside the window
    logic [1:0] idx; // register index of first byte
    logic hit_lo; // first byte maps to a register
    logic hit_hi; // second byte of a wide access maps
    logic [7:0] bank_reg [ADTR_NREGS]; // trim storage
    logic [15:0] rdata_next; // read value before register
    logic lock_reg; // sleep trim lock state
    localparam int SLP_IDX = int'(ADTR_OFS_TWO[1:0]); // lockable register index
    logic [ADTR_NREGS-1:0] wr_sel; // register takes a byte this cycle
    logic [7:0] wr_byte [ADTR_NREGS]; // byte offered to each register

    // either base selects the same bank
    always_comb begin
        win_hit = ((reg_addr & ADTR_BASE_MASK) == ADTR_BASE_BLOCKING) ||
                  ((reg_addr & ADTR_BASE_MASK) == ADTR_BASE_NONBLOCK);
        ofs = 8'(reg_addr & ADTR_WIN_MASK);
        idx = ofs[1:0];
        hit_lo = win_hit && (ofs >= ADTR_OFS_ZERO) && (ofs <= ADTR_OFS_THREE);
        // a wide access needs its second byte inside the bank too
        hit_hi = hit_lo && (ofs != ADTR_OFS_THREE);
    end

    // ****************************************
    // write lanes
    // ****************************************
    // one byte lane per register; wide writes cover idx and idx+1
    // kept combinational so the storage flops see plain non-blocking updates
    always_comb begin
        for (int i = 0; i < ADTR_NREGS; i++) begin
            wr_sel[i] = 1'b0; // no lane unless decoded below
            wr_byte[i] = 8'h00;
            if (reg_wr && hit_lo) begin
                if (!reg_wide && (i == int'(idx))) begin
                    // byte access always lands from the low data byte
                    wr_sel[i] = 1'b1;
                    wr_byte[i] = reg_wdata[7:0];
                end else if (reg_wide && hit_hi && (i == int'(idx))) begin
                    // wide access: high byte goes to the lower offset
                    wr_sel[i] = 1'b1;
                    wr_byte[i] = reg_wdata[15:8];
                end else if (reg_wide && hit_hi && (i == int'(idx) + 1)) begin
                    // low byte goes to the next offset
                    wr_sel[i] = 1'b1;
                    wr_byte[i] = reg_wdata[7:0];
                end
            end
        end
    end

    // ****************************************
    // trim storage
    // ****************************************
    // low_power is deliberately not an input here, so nothing drifts in sleep
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            // defaults on every reset; low_power never touches them
            bank_reg[0] <= ADTR_RST_ZERO;
            bank_reg[1] <= ADTR_RST_ONE;
            bank_reg[2] <= ADTR_RST_TWO;
            bank_reg[3] <= ADTR_RST_THREE;
        end else begin
            for (int i = 0; i < ADTR_NREGS; i++) begin
                if (wr_sel[i]) begin
                    if (i == SLP_IDX) begin
                        // locked sleep trim ignores the write entirely
                        if (!lock_reg) begin
                            bank_reg[i] <= wr_byte[i] & ADTR_SLP_MASK;
                        end
                    end else begin
                        bank_reg[i] <= wr_byte[i];
                    end
                end
            end
        end
    end

    // lock mirrors the stored bit; only reset can lower it
    assign lock_reg = bank_reg[2][ADTR_SLP_LOCK_BIT];

    // ****************************************
    // read path
    // ****************************************
    // unmapped bytes and reserved bits answer zero
    always_comb begin
        rdata_next = 16'h0000;
        if (hit_lo) begin
            if (reg_wide) begin
                if (hit_hi) begin
                    rdata_next = {bank_reg[idx], bank_reg[2'(idx + 2'd1)]};
                end
            end else begin
                rdata_next = {8'h00, bank_reg[idx]};
            end
        end
    end

    // read data and ack one cycle after the strobe
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= (reg_rd || reg_wr) && hit_lo && (!reg_wide || hit_hi);
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    // ****************************************
    // analog side outputs
    // ****************************************
    assign trim_reg_zero = bank_reg[0];
    assign trim_reg_one = bank_reg[1];
    assign trim_reg_two = bank_reg[2];
    assign trim_reg_three = bank_reg[3];
    assign sleep_ref_trim_locked = lock_reg;

    // ****************************************
    // checks
    // ****************************************
    // a locked sleep trim must not move, whatever is written to it
    a_lock_freezes_two: assert property (@(posedge core_clk) disable iff (!nrst)
        lock_reg |=> $stable(trim_reg_two))
        else $error("locked sleep trim changed");

    // only the asynchronous reset may release the lock
    a_lock_stays_set: assert property (@(posedge core_clk) disable iff (!nrst)
        lock_reg |=> lock_reg)
        else $error("sleep trim lock dropped without reset");

    // unimplemented bits of the sleep trim always read zero
    a_two_upper_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        (trim_reg_two & ~ADTR_SLP_MASK) == 8'h00)
        else $error("reserved sleep trim bits not zero");

    // low power alone never disturbs trims zero, one and three
    a_low_power_holds: assert property (@(posedge core_clk) disable iff (!nrst)
        (low_power && !reg_wr) |=> ($stable(trim_reg_zero) && $stable(trim_reg_one)
            && $stable(trim_reg_three)))
        else $error("trim changed in low power without write");

    // byte write to the first register lands one edge later
    a_byte_write_lands: assert property (@(posedge core_clk) disable iff (!nrst)
        (reg_wr && !reg_wide && hit_lo && idx == 2'd0)
        |=> trim_reg_zero == $past(reg_wdata[7:0]))
        else $error("byte write to first trim lost");

    // wide write splits high byte to the lower offset
    a_wide_write_lands: assert property (@(posedge core_clk) disable iff (!nrst)
        (reg_wr && reg_wide && win_hit && ofs == ADTR_OFS_ZERO)
        |=> (trim_reg_zero == $past(reg_wdata[15:8])
            && trim_reg_one == $past(reg_wdata[7:0])))
        else $error("wide write to first trim pair lost");

    // a simultaneous write would make the old read value differ from the flop
    a_window_decode: assert property (@(posedge core_clk) disable iff (!nrst)
        (reg_rd && !reg_wr && !reg_wide
            && (reg_addr == (ADTR_BASE_NONBLOCK | 10'(ADTR_OFS_THREE))))
        |=> (reg_ack && reg_rdata == {8'h00, trim_reg_three}))
        else $error("non-blocking window read wrong");

    // wide read returns both bytes of the pair
    a_wide_read_pair: assert property (@(posedge core_clk) disable iff (!nrst)
        (reg_rd && !reg_wr && reg_wide && win_hit && ofs == ADTR_OFS_ZERO)
        |=> reg_rdata == {trim_reg_zero, trim_reg_one})
        else $error("wide read of first trim pair wrong");

    // nothing outside the two windows is answered
    a_miss_no_ack: assert property (@(posedge core_clk) disable iff (!nrst)
        ((reg_rd || reg_wr) && !win_hit) |=> !reg_ack)
        else $error("ack for address outside windows");

    // unmapped offsets read as zero
    a_miss_reads_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        (reg_rd && !hit_lo) |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");

    // a wide access at the last offset would run past the bank
    a_wide_edge_refused: assert property (@(posedge core_clk) disable iff (!nrst)
        ((reg_wr || reg_rd) && reg_wide && win_hit && ofs == ADTR_OFS_THREE)
        |=> (!reg_ack && $stable(trim_reg_three)))
        else $error("wide access at last offset taken");

    // unlocked sleep trim takes the masked byte
    a_sleep_write_masked: assert property (@(posedge core_clk) disable iff (!nrst)
        (reg_wr && !reg_wide && hit_lo && ofs == ADTR_OFS_TWO && !lock_reg)
        |=> trim_reg_two == ($past(reg_wdata[7:0]) & ADTR_SLP_MASK))
        else $error("sleep trim write not masked");

    // one write with the lock bit set freezes the trim
    a_lock_on_write: assert property (@(posedge core_clk) disable iff (!nrst)
        (reg_wr && !reg_wide && hit_lo && ofs == ADTR_OFS_TWO
            && reg_wdata[ADTR_SLP_LOCK_BIT]) |=> lock_reg)
        else $error("sleep trim lock not taken from write");

    // every register is back at its default on the first edge after reset
    a_reset_defaults: assert property (@(posedge core_clk)
        $rose(nrst) |-> (trim_reg_zero == ADTR_RST_ZERO && trim_reg_one == ADTR_RST_ONE
            && trim_reg_two == ADTR_RST_TWO && trim_reg_three == ADTR_RST_THREE))
        else $error("trim default missing after reset");

endmodule : adtr_trim_bank

// File: tb/adtr_mcu_model.sv
// adtr_mcu_model: start-up software on the controller die copying factory trims.
// assumes the bench hands the trim bank port to this model while busy is high.
`timescale 1ns/100ps
module adtr_mcu_model
    import adtr_pkg::*;
#(
    parameter logic [31:0] FACTORY = 32'ha53c_15c3 // factory bytes, offsets f0..f3
)
(
    input wire logic core_clk,
    input wire logic go,
    input wire logic ack,
    output logic busy,
    output logic wr,
    output logic [9:0] addr,
    output logic [15:0] wdata
);
    // factory row already opened through the page index
    initial begin
        busy = 1'b0;
        wr = 1'b0;
        addr = 10'h000;
        wdata = 16'h0000;
        @(posedge go);
        // two wide words, the second covers the lockable register
        for (int i = 0; i < 2; i++) begin
            @(negedge core_clk);
            busy = 1'b1;
            wr = 1'b1;
            addr = ADTR_BASE_BLOCKING | {2'b00, ADTR_OFS_ZERO + 8'(2 * i)};
            wdata = (i == 0) ? FACTORY[31:16] : FACTORY[15:0];
            // bank takes the strobe here; holding it longer would write twice
            @(posedge core_clk);
            @(negedge core_clk);
            wr = 1'b0;
            // registered answer stands at the following edge
            @(posedge core_clk iff ack);
        end
        @(negedge core_clk);
        busy = 1'b0;
        // released lines show the inverse, not a stale word
        wdata = ~wdata;
    end
endmodule : adtr_mcu_model

// File: tb/test_analog_die_trim_registers.sv
// test_analog_die_trim_registers: self-checking bench for the trim bank.
// assumes adtr_pkg, adtr_trim_bank and adtr_mcu_model are compiled first.
`timescale 1ns/100ps
module test_analog_die_trim_registers;
    import adtr_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0, low_power = 1'b0, go = 1'b0;
    logic b_wr = 1'b0, b_rd = 1'b0, b_wide = 1'b0, busy, m_wr, reg_ack, locked;
    logic [9:0] b_addr = 10'h000, m_addr;
    logic [15:0] b_wdata = 16'h0000, m_wdata, reg_rdata;
    logic [7:0] t0, t1, t2, t3;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    // rows: address, byte written, byte read back through the other window
    logic [25:0] rows [5] = '{{10'h2f0, 8'h81, 8'h81}, {10'h3f1, 8'h7e, 8'h7e},
        {10'h2f3, 8'hff, 8'hff}, {10'h3f2, 8'he6, 8'h06}, {10'h2f4, 8'h55, 8'h00}};
    always #12.5 core_clk = ~core_clk;
    // hang guard, the whole run needs under a hundred cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            test_done();
        end
    end
    adtr_mcu_model adtr_mcu_model_i (.core_clk(core_clk), .go(go), .ack(reg_ack),
        .busy(busy), .wr(m_wr), .addr(m_addr), .wdata(m_wdata));
    adtr_trim_bank adtr_trim_bank_i (.core_clk(core_clk), .nrst(nrst),
        .low_power(low_power), .reg_addr(busy ? m_addr : b_addr), .reg_wr(m_wr | b_wr),
        .reg_rd(b_rd), .reg_wide(busy | b_wide), .reg_wdata(busy ? m_wdata : b_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .trim_reg_zero(t0), .trim_reg_one(t1),
        .trim_reg_two(t2), .trim_reg_three(t3), .sleep_ref_trim_locked(locked));
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one-cycle strobe; answer is settled at the following falling edge
    task automatic acc(input logic [9:0] a, input logic w, input logic wd, input logic [15:0] d);
        @(negedge core_clk);
        b_addr = a;
        b_wr = w;
        b_rd = !w;
        b_wide = wd;
        b_wdata = d;
        @(negedge core_clk);
        b_wr = 1'b0;
        b_rd = 1'b0;
    endtask : acc
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        chk({locked, t0, t1, t2, t3}, 33'h0);
        go = 1'b1;
        wait (busy);
        wait (!busy);
        chk(33'({t0, t1, t2, t3}), 33'ha53c_15c3);
        low_power = 1'b1;
        repeat (20) @(negedge core_clk);
        chk(33'({t0, t1, t2, t3}), 33'ha53c_15c3);
        low_power = 1'b0;
        $display("test load done");
        foreach (rows[i]) begin
            acc(rows[i][25:16], 1'b1, 1'b0, {8'h00, rows[i][15:8]});
            chk(33'(reg_ack), 33'(rows[i][23:18] == 6'h3c));
            acc(rows[i][25:16] ^ 10'h100, 1'b0, 1'b0, 16'h0000);
            chk(33'(reg_rdata), 33'(rows[i][7:0]));
        end
        $display("test rows done");
        acc(10'h3f2, 1'b1, 1'b0, 16'h0013);
        chk(33'({locked, t2}), 33'h013);
        acc(10'h3f2, 1'b1, 1'b0, 16'h001d);
        chk(33'({locked, t2}), 33'h11d);
        acc(10'h2f2, 1'b1, 1'b1, 16'h0044);
        chk(33'({reg_ack, locked, t2, t3}), 33'h31d44);
        acc(10'h2f3, 1'b1, 1'b1, 16'h9999);
        chk(33'({reg_ack, t3}), 33'h044);
        acc(10'h3f2, 1'b0, 1'b0, 16'h0000);
        chk(33'(reg_rdata), 33'h1d);
        acc(10'h3f0, 1'b0, 1'b1, 16'h0000);
        chk(33'({reg_ack, reg_rdata}), 33'h1817e);
        acc(10'h2f3, 1'b0, 1'b1, 16'h0000);
        chk(33'({reg_ack, reg_rdata}), 33'h0);
        nrst = 1'b0;
        @(negedge core_clk);
        chk({locked, t0, t1, t2, t3}, 33'h0);
        nrst = 1'b1;
        acc(10'h2f2, 1'b1, 1'b0, 16'h0012);
        chk(33'(t2), 33'h12);
        $display("test lock done");
        test_done();
    end
endmodule : test_analog_die_trim_registers
